/* File: dv/hbt_bus_responder.sv */
`timescale 1ns/1ps
`default_nettype none

module hbt_bus_responder
   import hbt_pkg::*;
(
   input wire logic clk,
   input wire logic strobe,
   input wire logic [32:0] pins,
   input wire logic [4:0] cmd,
   input wire logic oe,
   output logic txn_valid,
   output hbt_txn_type txn,
   output logic [7:0] tag
);
   logic phase_two;
   logic [4:0] first_cmd;
   logic [32:0] first_addr;

   always_ff @(posedge clk) begin
      phase_two <= strobe && oe;
      txn_valid <= phase_two && oe;
      if (strobe && oe) begin
         first_cmd <= cmd;
         first_addr <= pins;
      end
      // Floated pins carry nothing, so a second clock without drive is ignored
      if (phase_two) begin
         txn <= '{first_cmd, first_addr, pins[LANE_LSB +: 8], pins[LEN_LSB +: 2], 3'h0};
         tag <= pins[TAG_LSB +: 8];
      end
   end
endmodule : hbt_bus_responder

`default_nettype wire

/* File: dv/tb_host_bus_transfer_control.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_host_bus_transfer_control
   import hbt_pkg::*;
;
   localparam logic [7:0] TAG = 8'h5a;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic bus_reset_n = 1'b1;
   logic init_n = 1'b1;
   logic flush_n = 1'b1;
   logic halt_n = 1'b1;
   logic req_valid = 1'b0;
   hbt_req_type req = '0;
   logic flush_done = 1'b0;
   logic req_ready, strobe, addr_oe, chunk_valid, cache_inv, flush_req, restart, built_in_self_check, gate;
   logic [32:0] addr_out;
   logic [4:0] req_cmd;
   logic [1:0] chunk_index;
   logic txn_valid;
   hbt_txn_type txn;
   logic [7:0] tag;
   hbt_txn_type exp_q[$];
   logic [1:0] chk_q[$];
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int restarts = 0;
   int bists = 0;
   int oe_cycles = 0;
   int seed = 34;

   always #10 sys_clk = ~sys_clk;

   hbt_agent #(.DEFER_TAG(TAG)) i_dut (.SYS_CLK(sys_clk), .SRST(srst), .BUS_RESET_N(bus_reset_n),
      .INIT_N(init_n), .FLUSH_N(flush_n), .CLOCK_HALT_REQUEST_N(halt_n), .REQ_VALID(req_valid),
      .REQ(req), .REQ_READY(req_ready), .FLUSH_DONE(flush_done), .ADDRESS_STROBE_PIN(strobe),
      .ADDR_OUT(addr_out), .REQ_CMD(req_cmd), .ADDR_OE(addr_oe), .CHUNK_VALID(chunk_valid),
      .CHUNK_INDEX(chunk_index), .CACHE_INVALIDATE(cache_inv), .CACHE_FLUSH_REQ(flush_req),
      .CORE_RESTART(restart), .BUILT_IN_SELF_CHECK(built_in_self_check), .CORE_CLK_GATE(gate));

   hbt_bus_responder i_bus (.clk(sys_clk), .strobe(strobe), .pins(addr_out), .cmd(req_cmd),
      .oe(addr_oe), .txn_valid(txn_valid), .txn(txn), .tag(tag));

   task cmp(input bit ok, input string msg);
      n_compared++;
      if (!ok) begin
         n_errors++;
         $display("wrong value at %0t ns: %s", $time, msg);
      end
   endtask : cmp

   task end_sim;
      $display("comparisons %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   task piece(input hbt_req_type r, input logic [35:0] a, input int k);
      hbt_txn_type t;
      t.cmd = r.is_io ? (r.is_write ? CMD_IO_WR : CMD_IO_RD) : (r.is_write ? CMD_MEM_WR : CMD_MEM_RD);
      t.addr = r.is_io ? {19'h0, a[16] && a[15:3] == 13'h0, a[15:3]} : a[35:3];
      t.lanes = 8'((1 << k) - 1) << a[2:0];
      t.len = r.is_line ? LEN_LINE : LEN_PARTIAL;
      t.nchunk = 3'h0;
      exp_q.push_back(t);
      for (int i = 0; i < (r.is_line ? 4 : 1); i++) chk_q.push_back(a[4:3] ^ 2'(i));
   endtask : piece

   task model_req(input hbt_req_type r);
      int n, b, off, h;
      n = r.nbytes;
      if (r.is_io && n > 4) n = 4;
      b = (r.is_io && r.is_write) ? 4 : 8;
      off = r.addr[2:0] % b;
      h = (off + n > b) ? b - off : n;
      if (r.is_line) begin
         piece(r, r.addr, 8);
      end else begin
         piece(r, r.addr, h);
         if (h < n) piece(r, r.addr + 36'(h), n - h);
      end
   endtask : model_req

   task special(input logic [7:0] code);
      hbt_txn_type t;
      t = '0;
      t.cmd = CMD_SPECIAL;
      t.lanes = code;
      exp_q.push_back(t);
   endtask : special

   task send(input hbt_req_type r);
      int i;
      @(negedge sys_clk);
      req_valid = 1'b1;
      req = r;
      for (i = 0; i < 60; i++) begin
         @(posedge sys_clk);
         if (req_ready === 1'b1) break;
      end
      cmp(i < 60, "request not taken");
      model_req(r);
      @(negedge sys_clk);
      req_valid = 1'b0;
   endtask : send

   task wait_sig(input int s, input logic v);
      logic x;
      for (int i = 0; i < 40; i++) begin
         @(negedge sys_clk);
         x = s == 0 ? flush_req : s == 1 ? gate : s == 2 ? cache_inv : req_ready;
         if (x === v) break;
      end
      cmp(x === v, "control output did not settle");
   endtask : wait_sig

   task drain(input string name);
      wait_sig(3, 1'b1);
      repeat (4) @(negedge sys_clk);
      cmp(exp_q.size() == 0 && chk_q.size() == 0, "transfers missing");
      $display("test %s done", name);
   endtask : drain

   always @(posedge sys_clk) begin : watch
      hbt_txn_type e;
      cycles++;
      if (addr_oe === 1'b1) oe_cycles++;
      if (restart === 1'b1) restarts++;
      if (built_in_self_check === 1'b1) bists++;
      if (txn_valid === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : '0;
         cmp(txn.cmd === e.cmd, "command");
         if (e.cmd !== CMD_SPECIAL) cmp(txn.addr === e.addr && tag === TAG, "address");
         if (e.cmd !== CMD_SPECIAL) cmp(txn.len === e.len, "length");
         if (e.len !== LEN_LINE) cmp(txn.lanes === e.lanes, "lanes");
      end
      if (chunk_valid === 1'b1) cmp(chk_q.size() > 0 && chunk_index === chk_q.pop_front(), "chunk");
      if (cycles == 30000) begin
         cmp(1'b0, "timeout");
         end_sim();
      end
   end

   initial begin : main
      hbt_req_type r;
      hbt_req_type dir[5];
      int r0;
      dir = '{'{1'b0, 1'b0, 1'b0, 36'h000000105, 4'h8}, '{1'b1, 1'b0, 1'b0, 36'h000010000, 4'h3},
         '{1'b1, 1'b1, 1'b0, 36'hf0001fff2, 4'h4}, '{1'b1, 1'b0, 1'b0, 36'h000000046, 4'h8},
         '{1'b0, 1'b1, 1'b0, 36'h000000020, 4'h0}};
      repeat (12) @(negedge sys_clk);
      srst = 1'b0;
      repeat (6) @(negedge sys_clk);
      cmp(restarts == 1 && bists == 0, "start after reset");
      for (int i = 0; i < 4; i++) send('{1'b0, i[0], 1'b1, 36'h812345600 + 36'(i * 8), 4'h0});
      foreach (dir[i]) send(dir[i]);
      for (int i = 0; i < 40; i++) begin
         r.is_io = $random(seed) % 4 == 0;
         r.is_line = !r.is_io && $random(seed) % 3 == 0;
         r.is_write = 1'($random(seed));
         r.addr = 36'({$random(seed), $random(seed)});
         r.nbytes = 4'($unsigned($random(seed)) % 9);
         if (r.is_io && r.nbytes == 4'h0) r.nbytes = 4'h1;
         send(r);
      end
      drain("traffic");
      flush_n = 1'b0;
      wait_sig(0, 1'b1);
      cmp(req_ready === 1'b0, "request during flush");
      special(SPC_FLUSH_ACK);
      flush_done = 1'b1;
      @(negedge sys_clk);
      flush_done = 1'b0;
      flush_n = 1'b1;
      wait_sig(0, 1'b0);
      drain("flush");
      halt_n = 1'b0;
      special(SPC_STOP_ACK);
      wait_sig(1, 1'b1);
      repeat (4) @(negedge sys_clk);
      cmp(req_ready === 1'b0, "request while halted");
      halt_n = 1'b1;
      wait_sig(1, 1'b0);
      drain("halt");
      r0 = restarts;
      init_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      init_n = 1'b1;
      repeat (8) @(negedge sys_clk);
      cmp(restarts == r0 + 1 && cache_inv === 1'b0, "soft init");
      r0 = restarts;
      bus_reset_n = 1'b0;
      wait_sig(2, 1'b1);
      cmp(addr_oe === 1'b0 && strobe === 1'b0, "outputs during reset");
      init_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      bus_reset_n = 1'b1;
      repeat (6) @(negedge sys_clk);
      cmp(bists == 1 && restarts > r0 && cache_inv === 1'b0, "self check");
      init_n = 1'b1;
      repeat (6) @(negedge sys_clk);
      send(dir[0]);
      drain("resets");
      flush_n = 1'b0;
      bus_reset_n = 1'b0;
      repeat (6) @(negedge sys_clk);
      bus_reset_n = 1'b1;
      repeat (6) @(negedge sys_clk);
      oe_cycles = 0;
      flush_done = 1'b1;
      repeat (2) @(negedge sys_clk);
      flush_done = 1'b0;
      flush_n = 1'b1;
      send(dir[4]);
      repeat (40) @(negedge sys_clk);
      cmp(oe_cycles == 0 && exp_q.size() == 1 && chk_q.size() == 0, "pins floated");
      exp_q.delete();
      $display("test float done");
      end_sim();
   end
endmodule : tb_host_bus_transfer_control

`default_nettype wire

/* File: inc/hbt_pkg.sv */
package hbt_pkg;

   // Address widths and pin mapping (pin 0 carries address bit 3)
   localparam int ADDR_W = 36;
   localparam int PIN_W = 33;
   localparam int IO_ZERO_W = 19;

   // Request command codes, first request clock
   localparam logic [4:0] CMD_IO_RD = 5'h10;
   localparam logic [4:0] CMD_IO_WR = 5'h11;
   localparam logic [4:0] CMD_MEM_RD = 5'h0e;
   localparam logic [4:0] CMD_MEM_WR = 5'h0f;
   localparam logic [4:0] CMD_SPECIAL = 5'h08;
   localparam logic [4:0] CMD_NONE = 5'h00;

   // Special transaction codes carried on the byte lane field
   localparam logic [7:0] SPC_FLUSH_ACK = 8'h04;
   localparam logic [7:0] SPC_STOP_ACK = 8'h05;

   // Transfer length codes
   localparam logic [1:0] LEN_PARTIAL = 2'h0;
   localparam logic [1:0] LEN_HALF_LINE = 2'h1;
   localparam logic [1:0] LEN_LINE = 2'h2;

   // Second request clock field positions on the address pins
   localparam int TAG_LSB = 13;
   localparam int LANE_LSB = 5;
   localparam int LEN_LSB = 0;

   // Sizes in bytes and chunks
   localparam logic [3:0] SPAN_BYTES = 4'h8;
   localparam logic [3:0] IO_SPAN_BYTES = 4'h4;
   localparam logic [2:0] LINE_CHUNKS = 3'h4;
   localparam logic [2:0] PART_CHUNKS = 3'h1;
   localparam logic [7:0] ALL_LANES = 8'hff;

   // Control pins sampled high while idle
   localparam logic [3:0] CTL_IDLE = 4'hf;

   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_INFO, ST_DATA} hbt_state_type;

   typedef struct packed {
      logic is_io;
      logic is_write;
      logic is_line;
      logic [35:0] addr;
      logic [3:0] nbytes;
   } hbt_req_type;

   typedef struct packed {
      logic bus_reset_n;
      logic init_n;
      logic flush_n;
      logic halt_n;
   } hbt_ctl_type;

   typedef struct packed {
      logic [4:0] cmd;
      logic [32:0] addr;
      logic [7:0] lanes;
      logic [1:0] len;
      logic [2:0] nchunk;
   } hbt_txn_type;

endpackage : hbt_pkg

/* File: src/hbt_agent.sv */
// Behaviour
// - Memory requests carry full 36-bit address
// - I/O uses bits 16:3, upper bits zero
// - I/O bit 16 set only for wraparound
// - Line: four 8-byte chunks, aligned 32 bytes
// - Chunk order follows requested chunk index
// - Requested chunk always goes first
// - Part-line moves whole chunks in burst order
// - Never issue 16-byte part-line requests
// - Partial moves 0-8 bytes via lane selects
// - Split misaligned memory crossing 8 bytes
// - Split I/O writes crossing 4 bytes
// - I/O requests are 1 to 4 bytes
// - Address pins multiplexed over two clocks
// - Drive and sample on rising edge only
// - Deassert outputs within two clocks of reset
// - Hard reset invalidates caches, no writeback
// - Configuration sampled after reset seen inactive
// - Soft init restarts, caches kept
// - Init at reset release starts self check
// - Flush then issue flush acknowledge
// - Flush at reset release floats outputs; only ADDR_OE drops here, ADDRESS_STROBE_PIN and REQ_CMD still driven
// - Clock halt: stop grant, acknowledge, resume
// - Request phase spans two bus clocks
`timescale 1ns/1ps
`default_nettype none

module hbt_agent
   import hbt_pkg::*;
#(
   parameter logic [7:0] DEFER_TAG = 8'h00
)(
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic BUS_RESET_N,
   input wire logic INIT_N,
   input wire logic FLUSH_N,
   input wire logic CLOCK_HALT_REQUEST_N,
   input wire logic REQ_VALID,
   input wire hbt_req_type REQ,
   output logic REQ_READY,
   input wire logic FLUSH_DONE,
   output logic ADDRESS_STROBE_PIN,
   output logic [32:0] ADDR_OUT,
   output logic [4:0] REQ_CMD,
   output logic ADDR_OE,
   output logic CHUNK_VALID,
   output logic [1:0] CHUNK_INDEX,
   output logic CACHE_INVALIDATE,
   output logic CACHE_FLUSH_REQ,
   output logic CORE_RESTART,
   output logic BUILT_IN_SELF_CHECK,
   output logic CORE_CLK_GATE
);

   function automatic logic [7:0] lane_mask(input logic [2:0] off, input logic [3:0] n);
      logic [15:0] m;
      m = (16'h0001 << n) - 16'h0001;
      m = m << off;
      return m[7:0];
   endfunction : lane_mask

   function automatic hbt_txn_type make_txn(input logic is_io, input logic is_write,
                                            input logic is_line, input logic [35:0] addr,
                                            input logic [3:0] n);
      hbt_txn_type t;
      logic wrap;
      // bit 16 survives only for the bytes just above 64K
      wrap = addr[16] && (addr[15:3] == 13'h0);
      if (is_io) begin
         t.cmd = is_write ? CMD_IO_WR : CMD_IO_RD;
         t.addr = {{IO_ZERO_W{1'b0}}, wrap, addr[15:3]};
      end else begin
         t.cmd = is_write ? CMD_MEM_WR : CMD_MEM_RD;
         t.addr = addr[35:3];
      end
      t.len = is_line ? LEN_LINE : LEN_PARTIAL;
      t.lanes = is_line ? ALL_LANES : lane_mask(addr[2:0], n);
      t.nchunk = is_line ? LINE_CHUNKS : PART_CHUNKS;
      return t;
   endfunction : make_txn

   hbt_ctl_type ctl_m;
   hbt_ctl_type ctl_s;
   hbt_ctl_type ctl_p;
   hbt_state_type state;
   hbt_state_type next_state;
   hbt_txn_type txn;
   hbt_txn_type tail;
   logic tail_valid;
   logic flush_ack_pend;
   logic stop_ack_pend;
   logic float_out;
   logic rst_prev;
   logic burst_busy;

   // Control pins come from outside: two flops before use
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         ctl_m <= CTL_IDLE;
         ctl_s <= CTL_IDLE;
         ctl_p <= CTL_IDLE;
      end else begin
         ctl_m <= {BUS_RESET_N, INIT_N, FLUSH_N, CLOCK_HALT_REQUEST_N};
         ctl_s <= ctl_m;
         ctl_p <= ctl_s;
      end
   end

   wire logic rst_seen = !ctl_s.bus_reset_n;
   wire logic release_edge = rst_prev && !rst_seen;
   wire logic init_edge = !ctl_s.init_n && ctl_p.init_n && !rst_seen;
   wire logic flush_edge = !ctl_s.flush_n && ctl_p.flush_n && !rst_seen;
   wire logic halt_act = !ctl_s.halt_n;
   wire logic halt_edge = halt_act && ctl_p.halt_n && !rst_seen;
   // Soft init restarts the bus engine like reset but spares caches
   wire logic clear = rst_seen || init_edge;

   // Split decode for an incoming core access
   wire logic span_is4 = REQ.is_io && REQ.is_write;
   wire logic [3:0] room = span_is4 ? IO_SPAN_BYTES - {2'h0, REQ.addr[1:0]}
                                    : SPAN_BYTES - {1'h0, REQ.addr[2:0]};
   wire logic [3:0] n_cap = (REQ.is_io && REQ.nbytes > IO_SPAN_BYTES) ? IO_SPAN_BYTES
                                                                    : REQ.nbytes;
   wire logic [3:0] head_n = (!REQ.is_line && n_cap > room) ? room : n_cap;
   wire logic [3:0] tail_n = n_cap - head_n;
   wire logic [35:0] tail_addr = span_is4 ? {REQ.addr[35:2] + 34'h1, 2'h0}
                                          : {REQ.addr[35:3] + 33'h1, 3'h0};
   wire hbt_txn_type head_txn = make_txn(REQ.is_io, REQ.is_write, REQ.is_line, REQ.addr,
                                         head_n);
   wire hbt_txn_type tail_txn = make_txn(REQ.is_io, REQ.is_write, 1'b0, tail_addr, tail_n);
   wire hbt_txn_type spc_txn = '{cmd: CMD_SPECIAL, addr: 33'h0,
                                 lanes: flush_ack_pend ? SPC_FLUSH_ACK : SPC_STOP_ACK,
                                 len: LEN_PARTIAL, nchunk: 3'h0};
   wire logic [32:0] info_word = {12'h0, DEFER_TAG, txn.lanes, 3'h0, txn.len};

   wire logic launch_core = (state == ST_IDLE) && REQ_VALID && REQ_READY && !clear;
   wire logic launch_spc = (state == ST_IDLE) && !launch_core && !clear
                           && (flush_ack_pend || stop_ack_pend);
   wire logic launch_stop = launch_spc && !flush_ack_pend;
   wire logic data_done = (state == ST_DATA) && !burst_busy;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (launch_core || launch_spc) begin
               next_state = ST_ADDR;
            end
         end
         ST_ADDR: next_state = ST_INFO;
         ST_INFO: next_state = ST_DATA;
         ST_DATA: begin
            if (!burst_busy) begin
               next_state = tail_valid ? ST_ADDR : ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST || clear) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST || clear) begin
         txn <= '0;
         tail <= '0;
         tail_valid <= 1'b0;
      end else if (launch_core) begin
         txn <= head_txn;
         tail <= tail_txn;
         tail_valid <= (tail_n != 4'h0);
      end else if (launch_spc) begin
         txn <= spc_txn;
         tail_valid <= 1'b0;
      end else if (data_done && tail_valid) begin
         txn <= tail;
         tail_valid <= 1'b0;
      end
   end

   // pins drop one clock after reset is seen
   always_ff @(posedge SYS_CLK) begin
      if (SRST || clear) begin
         ADDRESS_STROBE_PIN <= 1'b0;
         ADDR_OUT <= 33'h0;
         REQ_CMD <= CMD_NONE;
         ADDR_OE <= 1'b0;
      end else begin
         ADDRESS_STROBE_PIN <= (state == ST_ADDR);
         ADDR_OUT <= (state == ST_ADDR) ? txn.addr : ((state == ST_INFO) ? info_word : 33'h0);
         REQ_CMD <= (state == ST_ADDR) ? txn.cmd : CMD_NONE;
         ADDR_OE <= ((state == ST_ADDR) || (state == ST_INFO)) && !float_out;
      end
   end

   // Ready only when no acknowledge waits and the core is running
   always_ff @(posedge SYS_CLK) begin
      if (SRST || clear) begin
         REQ_READY <= 1'b0;
      end else begin
         REQ_READY <= (next_state == ST_IDLE) && !flush_ack_pend && !stop_ack_pend
                      && !halt_act && !CORE_CLK_GATE && !CACHE_FLUSH_REQ && !flush_edge;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         rst_prev <= 1'b1;
         float_out <= 1'b0;
         BUILT_IN_SELF_CHECK <= 1'b0;
         CORE_RESTART <= 1'b0;
         CACHE_INVALIDATE <= 1'b0;
      end else begin
         rst_prev <= rst_seen;
         float_out <= rst_seen ? 1'b0 : (release_edge ? !ctl_s.flush_n : float_out);
         BUILT_IN_SELF_CHECK <= release_edge && !ctl_s.init_n;
         CORE_RESTART <= release_edge || init_edge;
         CACHE_INVALIDATE <= rst_seen;
      end
   end

   // flush and stop grant; a new event wins over its clear, except CORE_CLK_GATE, where halt release wins over launch_stop
   always_ff @(posedge SYS_CLK) begin
      if (SRST || rst_seen) begin
         CACHE_FLUSH_REQ <= 1'b0;
         flush_ack_pend <= 1'b0;
         stop_ack_pend <= 1'b0;
         CORE_CLK_GATE <= 1'b0;
      end else begin
         CACHE_FLUSH_REQ <= flush_edge || (CACHE_FLUSH_REQ && !FLUSH_DONE);
         flush_ack_pend <= (CACHE_FLUSH_REQ && FLUSH_DONE)
                           || (flush_ack_pend && !launch_spc);
         stop_ack_pend <= halt_edge || (stop_ack_pend && !launch_stop);
         CORE_CLK_GATE <= halt_act && (CORE_CLK_GATE || launch_stop);
      end
   end

   hbt_burst_order u_order (
      .clk(SYS_CLK),
      .rst(SRST || clear),
      .start(state == ST_INFO),
      .first_chunk(txn.addr[1:0]),
      .count(txn.nchunk),
      .busy(burst_busy),
      .chunk_valid(CHUNK_VALID),
      .chunk_index(CHUNK_INDEX)
   );

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);

   chk_io_high_zero: assert property (
      ADDRESS_STROBE_PIN && REQ_CMD[4] |-> ADDR_OUT[32:14] == 19'h0)
      else $error("I/O request drives upper address bits");

   chk_io_wrap_only: assert property (
      ADDRESS_STROBE_PIN && REQ_CMD[4] && ADDR_OUT[13] |-> ADDR_OUT[12:0] == 13'h0)
      else $error("I/O bit 16 set outside wraparound");

   chk_no_half_line: assert property (
      ADDRESS_STROBE_PIN |=> ADDR_OUT[LEN_LSB +: 2] != LEN_HALF_LINE)
      else $error("16-byte request issued");

   chk_line_lanes: assert property (
      ADDRESS_STROBE_PIN && !REQ_CMD[4] && REQ_CMD != CMD_SPECIAL
      ##1 ADDR_OUT[LEN_LSB +: 2] == LEN_LINE |-> ADDR_OUT[LANE_LSB +: 8] == ALL_LANES)
      else $error("Line request without all lanes");

   chk_io_size: assert property (
      ADDRESS_STROBE_PIN && REQ_CMD[4]
      |=> $countones(ADDR_OUT[LANE_LSB +: 8]) inside {[1:4]})
      else $error("I/O request outside one to four bytes");

   chk_io_wr_span: assert property (
      ADDRESS_STROBE_PIN && REQ_CMD == CMD_IO_WR
      |=> ADDR_OUT[LANE_LSB +: 4] == 4'h0 || ADDR_OUT[LANE_LSB + 4 +: 4] == 4'h0)
      else $error("I/O write crosses four-byte boundary");

   chk_request_two: assert property (
      ADDRESS_STROBE_PIN |=> !ADDRESS_STROBE_PIN ##1 !ADDRESS_STROBE_PIN)
      else $error("Request phase not two clocks");

   chk_first_chunk: assert property (
      $rose(CHUNK_VALID) |-> CHUNK_INDEX == txn.addr[1:0])
      else $error("Requested chunk not first");

   chk_reset_quiet: assert property (
      rst_seen |=> !ADDRESS_STROBE_PIN && !ADDR_OE && !REQ_READY)
      else $error("Outputs still active after reset seen");

   chk_reset_inval: assert property (
      rst_seen ##1 rst_seen |-> CACHE_INVALIDATE && !CACHE_FLUSH_REQ)
      else $error("Reset did not invalidate without flush");

   chk_built_in_self_check_config: assert property (
      release_edge && !ctl_s.init_n |=> BUILT_IN_SELF_CHECK && CORE_RESTART)
      else $error("Self check not started at release");

   chk_float_config: assert property (
      release_edge && !ctl_s.flush_n && !clear |=> ##1 !ADDR_OE)
      else $error("Outputs not floated for board test");

   chk_init_keeps: assert property (
      init_edge |=> CORE_RESTART && !CACHE_INVALIDATE && state == ST_IDLE)
      else $error("Soft init disturbed caches");

   chk_flush_ack: assert property (
      disable iff (SRST || rst_seen)
      CACHE_FLUSH_REQ && FLUSH_DONE
      |-> ##[1:40] (ADDRESS_STROBE_PIN && REQ_CMD == CMD_SPECIAL))
      else $error("Flush acknowledge not issued");

   chk_halt_gate: assert property (
      $rose(CORE_CLK_GATE) |=> ADDRESS_STROBE_PIN && REQ_CMD == CMD_SPECIAL
      ##1 ADDR_OUT[LANE_LSB +: 8] == SPC_STOP_ACK)
      else $error("Stop grant without acknowledge");

endmodule : hbt_agent

`default_nettype wire

/* File: src/hbt_burst_order.sv */
`timescale 1ns/1ps
`default_nettype none

module hbt_burst_order
   import hbt_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [1:0] first_chunk,
   input wire logic [2:0] count,
   output logic busy,
   output logic chunk_valid,
   output logic [1:0] chunk_index
);

   logic [1:0] first;
   logic [1:0] step;
   logic [2:0] remaining;
   wire logic last_step = ({1'b0, step} == (remaining - 3'h1));

   always_ff @(posedge clk) begin
      if (rst) begin
         busy <= 1'b0;
         first <= 2'h0;
         step <= 2'h0;
         remaining <= 3'h0;
         chunk_valid <= 1'b0;
         chunk_index <= 2'h0;
      end else if (start) begin
         busy <= (count != 3'h0);
         first <= first_chunk;
         step <= 2'h0;
         remaining <= count;
         chunk_valid <= 1'b0;
      end else if (busy) begin
         // Requested chunk first, then xor stepping
         chunk_valid <= 1'b1;
         chunk_index <= first ^ step;
         step <= step + 2'h1;
         busy <= !last_step;
      end else begin
         chunk_valid <= 1'b0;
      end
   end

endmodule : hbt_burst_order

`default_nettype wire
